//--- adcsq_pkg.sv
// Constants, register map and state codes of the conversion sequencer.
// Assumes a 40 MHz system clock and 8-bit registers on 32-bit AXI4-Lite.
package adcsq_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL2 = 8'h08;
    localparam logic [7:0] ADDR_RES_HI = 8'h0C;
    localparam logic [7:0] ADDR_RES_LO = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL0_EN_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_CHS_LSB = 2;
    localparam int CTRL1_PCFG_LSB = 0;
    localparam int CTRL1_VPOS_BIT = 4;
    localparam int CTRL1_VNEG_BIT = 5;
    localparam int CTRL2_CS_LSB = 0;
    localparam int CTRL2_ACQ_LSB = 3;
    localparam int CTRL2_FMT_BIT = 7;
    localparam int STATUS_FLAG_BIT = 0;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [4:0] CONV_TADS = 5'h0B;
    localparam logic [4:0] WAIT_TADS = 5'h02;
    localparam logic [9:0] SAR_MSB = 10'h200;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10,
        ST_WAIT = 2'b11
    } adcsq_state_t;

endpackage

//--- adcsq_tad_gen.sv
// Conversion clock period generator: one-cycle tick per period.
// Assumes rc_tick_i is a synchronous pulse from the internal RC source.
`timescale 1ns/10ps
`default_nettype none
module adcsq_tad_gen (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic sleep_i,
    input wire logic rc_tick_i,
    input wire logic [2:0] clk_sel_i,
    output logic tad_o
);
    logic [5:0] cnt_q;
    logic [5:0] last;
    logic use_rc;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    always_comb begin
        case (clk_sel_i) // RULE17
            3'h0: last = 6'h01;
            3'h1: last = 6'h07;
            3'h2: last = 6'h1F;
            3'h4: last = 6'h03;
            3'h5: last = 6'h0F;
            3'h6: last = 6'h3F;
            default: last = 6'h00;
        endcase
    end

    assign use_rc = (clk_sel_i[1:0] == 2'h3);

    // System clock stops in sleep, so only the RC source keeps ticking
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= 6'h00;
        end else if (!run_i || use_rc) begin
            cnt_q <= 6'h00;
        end else if (!sleep_i) begin // RULE4
            cnt_q <= (cnt_q == last) ? 6'h00 : cnt_q + 6'h01;
        end
    end

    assign tad_o = run_i && (use_rc ? rc_tick_i
                                    : (!sleep_i && cnt_q == last)); // RULE4
endmodule // adcsq_tad_gen
`default_nettype wire

//--- adcsq_core.sv
// Successive-approximation conversion sequencer with AXI4-Lite registers.
// Assumes an external comparator and a 10-bit trial DAC on the analog side.
// Functional notes
// [RULE1] On completion load result, clear busy bit, set done flag.
// [RULE2] Reset clears control registers, turns converter off, aborts work.
// [RULE3] Power-on reset leaves the result pair untouched and undefined.
// [RULE4] In sleep only the internal RC clock keeps conversions going.
// [RULE5] Software picks supply rails or external pins as references.
// [RULE6] Successive approximation yields a code of 1024 steps.
// [RULE7] Each converter pin is individually analog or digital; code uses a 4-bit field: pins below 15 minus it analog, all if under 4.
// [RULE8] Zero acquisition field: start stops sampling, converts at once.
// [RULE9] Nonzero field: sample programmed periods, then convert itself.
// [RULE10] After each conversion sampling resumes on the selected channel.
// [RULE11] No status of acquisition end; busy stays set through both.
// [RULE12] At least two clock periods pass before the next acquisition.
// [RULE13] Holding capacitor is disconnected for the whole conversion.
// [RULE14] Software configures, enables, starts, waits, reads, clears flag.
// [RULE15] Software samples a new channel long enough before converting.
// [RULE16] Acquisition codes give 0,2,4,6,8,12,16,20 periods.
// [RULE17] Clock field selects system clock divisors or the RC source.
// [RULE18] Conversion takes eleven periods from start to result update.
// [RULE19] Clearing start mid-conversion aborts, keeps previous result.
// [RULE20] With converter disabled nothing runs and busy reads idle.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module adcsq_core (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sleep_i,
    input wire logic rc_tick_i,
    input wire logic comp_i,
    output logic [3:0] channel_o,
    output logic sample_o,
    output logic [9:0] dac_code_o,
    output logic vref_pos_ext_o,
    output logic vref_neg_ext_o,
    output logic [11:0] analog_pin_o
);
    import adcsq_pkg::*;
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] acq_tads(input logic [2:0] code);
        case (code) // RULE16
            3'h0: acq_tads = 5'h00;
            3'h1: acq_tads = 5'h02;
            3'h2: acq_tads = 5'h04;
            3'h3: acq_tads = 5'h06;
            3'h4: acq_tads = 5'h08;
            3'h5: acq_tads = 5'h0C;
            3'h6: acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction
    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] r);
        is_addr = (a == r);
    endfunction
    logic [7:0] ctrl0_q, ctrl1_q, ctrl2_q;
    logic [9:0] result_q, sar_q, bit_mask;
    logic flag_q, busy_q, wstrb0_q, aw_got_q, w_got_q;
    logic [4:0] cnt_q, acq_len;
    adcsq_state_t state_q;
    logic tad, en, wr_fire, done, abort;
    logic [7:0] awaddr_q, wbyte_q, res_hi, res_lo;
    assign en = ctrl0_q[CTRL0_EN_BIT];
    assign acq_len = acq_tads(ctrl2_q[CTRL2_ACQ_LSB +: 3]);
    assign bit_mask = SAR_MSB >> cnt_q;
    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign s_axi_awready_o = !aw_got_q && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_got_q && !s_axi_bvalid_o;
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid_o;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_got_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_got_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            w_got_q <= 1'b0;
            wbyte_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_q <= 1'b1;
            wbyte_q <= s_axi_wdata_i[7:0];
            wstrb0_q <= s_axi_wstrb_i[0];
        end else if (wr_fire) begin
            w_got_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (awaddr_q > ADDR_STATUS || awaddr_q[1:0] != 2'h0)
                             ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end
    logic wr0;
    assign wr0 = wr_fire && wstrb0_q;
    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin // RULE2
            ctrl0_q <= CTRL_RESET;
            ctrl1_q <= CTRL_RESET;
            ctrl2_q <= CTRL_RESET;
        end else if (wr0) begin
            if (is_addr(awaddr_q, ADDR_CTRL0)) begin
                ctrl0_q <= wbyte_q & 8'h3D;
            end
            if (is_addr(awaddr_q, ADDR_CTRL1)) begin
                ctrl1_q <= wbyte_q & 8'h3F;
            end
            if (is_addr(awaddr_q, ADDR_CTRL2)) begin
                ctrl2_q <= wbyte_q & 8'hBF;
            end
        end
    end
    // Start needs the converter already on; turning on and starting in
    // one write is not accepted.
    logic go_set, go_clr;
    assign go_set = wr0 && is_addr(awaddr_q, ADDR_CTRL0) && en &&
                    wbyte_q[CTRL0_GO_BIT] && wbyte_q[CTRL0_EN_BIT];
    assign go_clr = wr0 && is_addr(awaddr_q, ADDR_CTRL0) &&
                    !wbyte_q[CTRL0_GO_BIT];
    assign abort = busy_q && go_clr && !go_set;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_q <= 1'b0;
        end else if (go_set) begin
            busy_q <= 1'b1;
        end else if (done || go_clr || !en) begin // RULE1 RULE19 RULE20
            busy_q <= 1'b0;
        end
    end
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_q <= 1'b0;
        end else if (done) begin // RULE1
            flag_q <= 1'b1;
        end else if (wr0 && is_addr(awaddr_q, ADDR_STATUS) &&
                     wbyte_q[STATUS_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    adcsq_tad_gen u_tad (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(state_q != ST_IDLE),
        .sleep_i(sleep_i),
        .rc_tick_i(rc_tick_i),
        .clk_sel_i(ctrl2_q[CTRL2_CS_LSB +: 3]),
        .tad_o(tad)
    );
    assign done = (state_q == ST_CONV) && busy_q && tad &&
                  (cnt_q == CONV_TADS - 5'h01); // RULE18
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin // RULE2
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end else if (!en) begin // RULE20
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 5'h00;
                    if (busy_q) begin
                        state_q <= (acq_len == 5'h00) ? ST_CONV // RULE8
                                                      : ST_ACQ; // RULE9
                    end
                end
                ST_ACQ: begin
                    if (!busy_q) begin
                        state_q <= ST_WAIT;
                        cnt_q <= 5'h00;
                    end else if (tad && cnt_q == acq_len - 5'h01) begin
                        state_q <= ST_CONV; // RULE9
                        cnt_q <= 5'h00;
                    end else if (tad) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                ST_CONV: begin
                    if (!busy_q || done) begin // RULE19
                        state_q <= ST_WAIT;
                        cnt_q <= 5'h00;
                    end else if (tad) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                ST_WAIT: begin
                    if (tad && cnt_q == WAIT_TADS - 5'h01) begin
                        state_q <= ST_IDLE; // RULE12 RULE10
                        cnt_q <= 5'h00;
                    end else if (tad) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= 5'h00;
                end
            endcase
        end
    end
    // Trial code: one bit decided per period, MSB first
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sar_q <= 10'h000;
        end else if (state_q != ST_CONV) begin
            sar_q <= SAR_MSB;
        end else if (tad && cnt_q < 5'h0A) begin // RULE6
            sar_q <= ((comp_i ? sar_q : (sar_q & ~bit_mask)) |
                     (bit_mask >> 1));
        end
    end
    // No reset: contents survive any reset and start undefined
    always_ff @(posedge clk_i) begin
        if (done) begin // RULE1 RULE3
            result_q <= sar_q;
        end else if (wr0 && is_addr(awaddr_q, ADDR_RES_HI)) begin
            result_q <= ctrl2_q[CTRL2_FMT_BIT]
                        ? {wbyte_q[1:0], result_q[7:0]}
                        : {wbyte_q, result_q[1:0]};
        end else if (wr0 && is_addr(awaddr_q, ADDR_RES_LO)) begin
            result_q <= ctrl2_q[CTRL2_FMT_BIT]
                        ? {result_q[9:8], wbyte_q}
                        : {result_q[9:2], wbyte_q[7:6]};
        end
    end
    // ------------------------------------------------------------------
    // Analog-side outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sample_o <= 1'b0;
            dac_code_o <= 10'h000;
            channel_o <= 4'h0;
            vref_pos_ext_o <= 1'b0;
            vref_neg_ext_o <= 1'b0;
            analog_pin_o <= 12'hFFF;
        end else begin
            sample_o <= en && busy_q && !go_clr &&
                        (state_q == ST_IDLE ? acq_len != 5'h00
                                            : state_q == ST_ACQ) &&
                        !(state_q == ST_ACQ && tad &&
                          cnt_q == acq_len - 5'h01) ||
                        en && !busy_q && state_q == ST_IDLE; // RULE10 RULE13
            dac_code_o <= sar_q;
            channel_o <= ctrl0_q[CTRL0_CHS_LSB +: 4];
            vref_pos_ext_o <= ctrl1_q[CTRL1_VPOS_BIT]; // RULE5
            vref_neg_ext_o <= ctrl1_q[CTRL1_VNEG_BIT]; // RULE5
            for (int i = 0; i < 12; i++) begin // RULE7
                analog_pin_o[i] <= (ctrl1_q[3:0] < 4'h4) ||
                    (i < 15 - int'(ctrl1_q[3:0]));
            end
        end
    end
    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign res_hi = ctrl2_q[CTRL2_FMT_BIT] ? {6'h00, result_q[9:8]}
                                           : result_q[9:2];
    assign res_lo = ctrl2_q[CTRL2_FMT_BIT] ? result_q[7:0]
                                           : {result_q[1:0], 6'h00};
    assign s_axi_arready_o = !s_axi_rvalid_o;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= RESP_OKAY;
            case (s_axi_araddr_i)
                ADDR_CTRL0: s_axi_rdata_o <= {24'h000000, ctrl0_q[7:2],
                                              busy_q && en, en}; // RULE11
                ADDR_CTRL1: s_axi_rdata_o <= {24'h000000, ctrl1_q};
                ADDR_CTRL2: s_axi_rdata_o <= {24'h000000, ctrl2_q};
                ADDR_RES_HI: s_axi_rdata_o <= {24'h000000, res_hi};
                ADDR_RES_LO: s_axi_rdata_o <= {24'h000000, res_lo};
                ADDR_STATUS: s_axi_rdata_o <= {31'h00000000, flag_q};
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_done_sets_flag: assert property (done |=> flag_q && !busy_q &&
        state_q == ST_WAIT) else $error("done did not set flag"); // RULE1
    a_off_is_idle: assert property (!en |=> state_q == ST_IDLE && !busy_q)
        else $error("disabled converter not idle"); // RULE20
    a_zero_acq: assert property (state_q == ST_IDLE && busy_q && en &&
        acq_len == 5'h00 |=> state_q == ST_CONV)
        else $error("zero acquisition did not convert"); // RULE8
    a_prog_acq: assert property (state_q == ST_IDLE && busy_q && en &&
        acq_len != 5'h00 |=> state_q == ST_ACQ ##1 sample_o)
        else $error("programmed acquisition skipped"); // RULE9
    a_hold_open: assert property (state_q == ST_CONV |-> ##1 !sample_o)
        else $error("capacitor connected in conversion"); // RULE13
    a_busy_through: assert property (state_q inside {ST_ACQ, ST_CONV} &&
        !go_clr && en |=> busy_q || state_q == ST_WAIT)
        else $error("busy dropped early"); // RULE11
    a_abort_keeps: assert property (abort && state_q == ST_CONV |=>
        result_q == $past(result_q) ##1 state_q == ST_WAIT)
        else $error("abort changed result"); // RULE19
    a_conv_bound: assert property (state_q == ST_CONV |->
        cnt_q < CONV_TADS) else $error("conversion too long"); // RULE18
    a_wait_min: assert property (state_q == ST_CONV ##1
        state_q == ST_WAIT |-> state_q == ST_WAIT [*2])
        else $error("wait shorter than two cycles"); // RULE12
    a_resume: assert property (state_q == ST_WAIT ##1 state_q == ST_IDLE
        && !busy_q && en |=> sample_o)
        else $error("sampling not resumed"); // RULE10
    c_full_conv: cover property (done ##[1:200] state_q == ST_IDLE);
    c_acq_conv: cover property (state_q == ST_ACQ ##[1:500] done);
    c_abort: cover property (abort && state_q == ST_CONV);
endmodule // adcsq_core
`default_nettype wire

//--- adcsq_analog_model.sv
// Analog pins, holding capacitor and comparator beside the sequencer.
// Assumes the bench drives twelve 10-bit pin levels, pin 0 lowest.
`timescale 1ns/10ps
`default_nettype none
module adcsq_analog_model (
    input wire logic clk_i,
    input wire logic [119:0] levels_i,
    input wire logic [3:0] channel_i,
    input wire logic sample_i,
    input wire logic [9:0] dac_code_i,
    output logic comp_o
);
    logic [9:0] held_q;
    logic [9:0] pin_d;

    // Unused channels read as ground
    assign pin_d = (channel_i < 4'hC) ? levels_i[channel_i*10 +: 10] : 10'h000;

    // Cap follows the pin only while connected
    always_ff @(posedge clk_i) begin
        if (sample_i) begin
            held_q <= pin_d;
        end
    end

    assign comp_o = (held_q >= dac_code_i);
endmodule // adcsq_analog_model
`default_nettype wire

//--- tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes adcsq_pkg, adcsq_core and the analog model come first.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import adcsq_pkg::*;
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wdt = 32'h0;
    logic [31:0] rdt;
    logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic slp = 1'h0, rct = 1'h0;
    logic awr, wrd, bv, arr, rv, cmp, smp, vp, vn;
    logic [1:0] bre, rre;
    logic [3:0] ch;
    logic [9:0] dac;
    logic [11:0] apin;
    logic [119:0] lvl = '0;
    int n_fail = 0, checks = 0, cyc = 0;

    adcsq_core i_adcsq_core (.clk_i, .reset_i, .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdt),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdt), .s_axi_rresp_o(rre), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rr), .sleep_i(slp), .rc_tick_i(rct), .comp_i(cmp),
        .channel_o(ch), .sample_o(smp), .dac_code_o(dac),
        .vref_pos_ext_o(vp), .vref_neg_ext_o(vn), .analog_pin_o(apin));
    adcsq_analog_model i_adcsq_analog_model (.clk_i, .levels_i(lvl),
        .channel_i(ch), .sample_i(smp), .dac_code_i(dac), .comp_o(cmp));

    initial forever #12.5 clk_i = ~clk_i;
    // Free-running RC source, phase unrelated to any start
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        rct <= (cyc % 5 == 4);
        if (cyc == 40000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        bit ta, tw;
        ta = 0;
        tw = 0;
        awa <= a;
        wdt <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        while (!(ta && tw)) begin
            @(posedge clk_i);
            if (!ta && awr) begin
                ta = 1;
                awv <= 1'h0;
            end
            if (!tw && wrd) begin
                tw = 1;
                wv <= 1'h0;
            end
        end
        do @(posedge clk_i); while (bv !== 1'h1);
        br <= 1'h0;
        chk("bresp", bre, (a > 8'h14) ? RESP_SLVERR : RESP_OKAY);
        @(posedge clk_i);
    endtask

    task automatic rc(input logic [7:0] a, e, input string nm);
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        do @(posedge clk_i); while (arr !== 1'h1);
        arv <= 1'h0;
        do @(posedge clk_i); while (rv !== 1'h1);
        rr <= 1'h0;
        chk("rresp", rre, (a > 8'h14) ? RESP_SLVERR : RESP_OKAY);
        chk(nm, rdt, {24'h0, e});
        @(posedge clk_i);
    endtask

    // One full start: enable, settle, start, time both phases, read back
    task automatic conv(input logic [2:0] cs, aq, input int d, na,
                        input logic [3:0] c, input logic f,
                        input logic [9:0] lv);
        int t;
        t = 0;
        lvl[c*10 +: 10] <= lv;
        axw(ADDR_CTRL2, {f, 1'h0, aq, cs});
        axw(ADDR_CTRL0, {2'h0, c, 2'h1});
        repeat (4) @(posedge clk_i);
        axw(ADDR_CTRL0, {2'h0, c, 2'h3});
        while (smp === 1'h1) begin
            @(posedge clk_i);
            t++;
        end
        chk("acq_len", (t + d >= na * d) && (t <= na * d + d + 3), 1);
        lvl[c*10 +: 10] <= ~lv;
        t = 0;
        while (smp !== 1'h1) begin
            @(posedge clk_i);
            t++;
        end
        chk("conv_len", (t + d >= 13 * d) && (t <= 14 * d + 2), 1);
        chk("channel", ch, c);
        rc(ADDR_CTRL0, {2'h0, c, 2'h1}, "busy");
        rc(ADDR_STATUS, 8'h01, "flag");
        rc(ADDR_RES_HI, f ? {6'h0, lv[9:8]} : lv[9:2], "res_hi");
        rc(ADDR_RES_LO, f ? lv[7:0] : {lv[1:0], 6'h0}, "res_lo");
        axw(ADDR_STATUS, 8'h01);
    endtask

    task automatic t_regs;
        rc(ADDR_CTRL0, 8'h00, "ctrl0");
        rc(ADDR_CTRL1, 8'h00, "ctrl1");
        rc(ADDR_CTRL2, 8'h00, "ctrl2");
        rc(ADDR_STATUS, 8'h00, "status");
        rc(8'h18, 8'h00, "unmapped");
        axw(8'h18, 8'hFF);
        for (int k = 0; k < 16; k++) begin
            axw(ADDR_CTRL1, {2'h0, k[1:0], k[3:0]});
            chk("pins", apin, (k < 4) ? 12'hFFF : 12'hFFF >> (k - 3));
            chk("vref", {vn, vp}, k[1:0]);
        end
        axw(ADDR_CTRL1, 8'h00);
    endtask

    task automatic t_seq;
        int na[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
        int dv[8] = '{2, 8, 32, 5, 4, 16, 64, 5};
        for (int i = 0; i < 8; i++) begin
            conv(3'h0, i[2:0], 2, na[i], i[3:0], i[0], 10'h155 + 10'(i * 73));
        end
        for (int i = 0; i < 8; i++) begin
            conv(i[2:0], 3'h1, dv[i], 2, 4'(i + 4), 1'h1, 10'h3FF - 10'(i * 91));
        end
    endtask

    task automatic t_abort;
        axw(ADDR_RES_HI, 8'h5A);
        axw(ADDR_RES_LO, 8'hC3);
        axw(ADDR_CTRL2, 8'h86);
        axw(ADDR_CTRL0, 8'h09);
        axw(ADDR_CTRL0, 8'h0B);
        repeat (100) @(posedge clk_i);
        rc(ADDR_CTRL0, 8'h0B, "busy_mid");
        axw(ADDR_CTRL0, 8'h09);
        // Right-justified: only two high bits kept from the high write
        rc(ADDR_RES_HI, 8'h02, "kept_hi");
        rc(ADDR_RES_LO, 8'hC3, "kept_lo");
        rc(ADDR_STATUS, 8'h00, "no_flag");
        while (smp !== 1'h1) @(posedge clk_i);
        axw(ADDR_CTRL0, 8'h00);
        axw(ADDR_CTRL0, 8'h0A);
        rc(ADDR_CTRL0, 8'h08, "off_start");
        chk("off_sample", smp, 1'h0);
        axw(ADDR_CTRL0, 8'h0B);
        rc(ADDR_CTRL0, 8'h09, "on_start");
    endtask

    task automatic t_sleep;
        axw(ADDR_CTRL2, 8'h80);
        slp <= 1'h1;
        axw(ADDR_CTRL0, 8'h0B);
        repeat (200) @(posedge clk_i);
        rc(ADDR_CTRL0, 8'h0B, "frozen");
        slp <= 1'h0;
        while (smp !== 1'h1) @(posedge clk_i);
        rc(ADDR_STATUS, 8'h01, "thawed");
        axw(ADDR_STATUS, 8'h01);
        slp <= 1'h1;
        conv(3'h7, 3'h0, 5, 0, 4'h3, 1'h1, 10'h2C4);
        slp <= 1'h0;
    endtask

    task automatic t_rst;
        axw(ADDR_RES_HI, 8'h3C);
        axw(ADDR_RES_LO, 8'h96);
        axw(ADDR_CTRL2, 8'h86);
        axw(ADDR_CTRL0, 8'h09);
        axw(ADDR_CTRL0, 8'h0B);
        repeat (50) @(posedge clk_i);
        reset_i <= 1'h1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        @(posedge clk_i);
        rc(ADDR_CTRL0, 8'h00, "rst_ctrl0");
        rc(ADDR_CTRL2, 8'h00, "rst_ctrl2");
        chk("rst_sample", smp, 1'h0);
        // Written right-justified as 0x096, read back left-justified
        rc(ADDR_RES_HI, 8'h25, "rst_hi");
        rc(ADDR_RES_LO, 8'h80, "rst_lo");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'h0;
        @(posedge clk_i);
        t_regs();
        t_seq();
        t_abort();
        t_sleep();
        t_rst();
        stop_test();
    end
endmodule // tb
`default_nettype wire
